// >>> bench/tb.sv
// Purpose: self-checking bench for the conversion sequencer
// Assumes: the bench stands in for the converter core and the register writes
// Notes: codes come from a fixed-seed shift register, corner codes mixed in
`timescale 1ns/1ps
module tb;
   import acs_pkg::*;
   logic clk = 1'b0, rst = 1'b1, differential_sel = 1'b0, command_wr = 1'b0, event_in = 1'b0;
   logic pos_sel_wr = 1'b0, neg_sel_wr = 1'b0, reference_sel_wr = 1'b0, conv_done = 1'b0;
   logic continuous_run = 1'b0, left_align = 1'b0;
   logic [2:0] mode_sel = 3'h0, clock_divider_sel = 3'h0, irq_control_reg = 3'h0;
   logic [2:0] flag_clear = 3'h0;
   logic [1:0] start_sel = 2'h0;
   logic [5:0] positive_input_sel = 6'h00, negative_input_sel = 6'h00;
   logic [3:0] accum_count_sel = 4'h0;
   logic [11:0] conv_data = 12'h000;
   logic conv_start, conv_res8, conv_differential_sel, adc_clk, busy, irq;
   logic [2:0] irq_flag_reg;
   logic [15:0] sample_reg;
   logic [31:0] result_reg;
   logic [31:0] seed = 32'h0001_1FAC;
   int bad_count = 0;
   int num_checks = 0;
   int cycles = 0;
   int n;

   acs_sequencer dut (.clk(clk), .rst(rst), .mode_sel(mode_sel),
      .differential_sel(differential_sel),
      .start_sel(start_sel), .command_wr(command_wr), .event_in(event_in),
      .positive_input_sel(positive_input_sel), .pos_sel_wr(pos_sel_wr),
      .negative_input_sel(negative_input_sel), .neg_sel_wr(neg_sel_wr),
      .reference_sel_wr(reference_sel_wr), .accum_count_sel(accum_count_sel),
      .continuous_run(continuous_run), .left_align(left_align),
      .clock_divider_sel(clock_divider_sel), .irq_control_reg(irq_control_reg),
      .flag_clear(flag_clear), .conv_done(conv_done), .conv_data(conv_data),
      .conv_start(conv_start), .conv_res8(conv_res8), .conv_differential_sel(conv_differential_sel), .adc_clk(adc_clk),
      .busy(busy), .irq_flag_reg(irq_flag_reg), .irq(irq), .sample_reg(sample_reg),
      .result_reg(result_reg));

   // ----------------------------------------------------------------
   // clock, hang guard, helpers
   // ----------------------------------------------------------------
   initial
   begin
      forever #10 clk = ~clk;
   end

   // cut a hang short
   always @(posedge clk)
   begin
      cycles <= cycles + 1;
      if (cycles == 40000)
      begin
         bad_count++;
         stop_test();
      end
   end

   // shift register for random codes
   function automatic void step();
      seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
   endfunction

   // expected sample for one code
   function automatic logic [15:0] exp_smp(input logic [2:0] m, input logic d, input logic la,
                                           input logic [11:0] c);
      if (m == MODE_SINGLE8)
         return d ? {{8{c[7]}}, c[7:0]} : {8'h00, c[7:0]};
      if (la && m != MODE_SERIES && m != MODE_BURST)
         return {c, 4'h0};
      return d ? {{4{c[11]}}, c} : {4'h0, c};
   endfunction

   task automatic chkv(input logic [31:0] got, input logic [31:0] exp, input string what);
      num_checks++;
      if (got !== exp)
      begin
         bad_count++;
         $display("BAD %0t %s got %h expected %h", $time, what, got, exp);
      end
   endtask

   task automatic chkb(input logic got, input logic exp, input string what);
      num_checks++;
      if (got !== exp)
      begin
         bad_count++;
         $display("BAD %0t %s got %b expected %b", $time, what, got, exp);
      end
   endtask

   task automatic stop_test();
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   // ----------------------------------------------------------------
   // bus-free drivers: config, command, triggers, core answer
   // ----------------------------------------------------------------
   task automatic cfg(input logic [2:0] m, input logic d, input logic la, input logic [3:0] k);
      @(posedge clk);
      step();
      mode_sel <= m;
      differential_sel <= d;
      left_align <= la;
      accum_count_sel <= k;
      irq_control_reg <= seed[2:0];
      clock_divider_sel <= seed[5:3];
      flag_clear <= 3'h7;
      @(posedge clk);
      flag_clear <= 3'h0;
   endtask

   // one command write, returns in the cycle after the take edge
   task automatic cmd(input logic [1:0] s);
      @(posedge clk);
      start_sel <= s;
      command_wr <= 1'b1;
      @(posedge clk);
      command_wr <= 1'b0;
      @(negedge clk);
   endtask

   // pulse 0 event, 1 positive select, 2 negative select, 3 reference write
   task automatic pulse(input int w, input logic [5:0] code);
      @(posedge clk);
      event_in <= (w == 0);
      pos_sel_wr <= (w == 1);
      neg_sel_wr <= (w == 2);
      reference_sel_wr <= (w == 3);
      positive_input_sel <= code;
      negative_input_sel <= code;
      @(posedge clk);
      {event_in, pos_sel_wr, neg_sel_wr, reference_sel_wr} <= 4'h0;
      @(negedge clk);
   endtask

   task automatic wait_start(output int cnt);
      cnt = 0;
      while (conv_start !== 1'b1 && cnt < 200)
      begin
         @(negedge clk);
         cnt++;
      end
   endtask

   // half period of the converter clock, seen at falling edges
   task automatic chk_div();
      logic b;
      int t;
      @(negedge clk);
      b = adc_clk;
      while (adc_clk === b)
         @(negedge clk);
      b = adc_clk;
      t = 0;
      while (adc_clk === b && t < 300)
      begin
         @(negedge clk);
         t++;
      end
      chkv(t, 1 << clock_divider_sel, "converter clock half period");
   endtask

   // core answer one cycle after the start pulse
   task automatic conv(input logic [11:0] c);
      @(posedge clk);
      conv_done <= 1'b1;
      conv_data <= c;
      @(posedge clk);
      conv_done <= 1'b0;
      conv_data <= ~c;
      @(negedge clk);
   endtask

   // ----------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------
   task automatic one(input logic [2:0] m, input logic d, input logic la);
      logic [11:0] c;
      logic [15:0] s;
      cfg(m, d, la, 4'h0);
      step();
      c = (m == MODE_SINGLE8) ? {4'h0, seed[7:0]} : seed[11:0];
      s = exp_smp(m, d, la, c);
      cmd(START_NOW);
      wait_start(n);
      chkv(n, 0, "start delay");
      chkb(conv_res8, m == MODE_SINGLE8, "res8");
      chkb(conv_differential_sel, d, "differential_sel");
      conv(c);
      chkv({16'h0000, sample_reg}, {16'h0000, s}, "sample");
      chkv(result_reg, d ? {{16{s[15]}}, s} : {16'h0000, s}, "single result");
      chkv({29'h0, irq_flag_reg}, 32'h3, "ready flags");
      chkb(irq, |(irq_control_reg & 3'h3), "irq");
      chkb(busy, 1'b0, "one per trigger");
      chk_div();
   endtask

   task automatic acc(input logic [2:0] m, input logic [3:0] k, input logic d, input logic la,
                      input logic corner);
      int sum;
      int sh;
      logic [11:0] c;
      logic [31:0] r0;
      logic [31:0] sc;
      cfg(m, d, la, k);
      sum = 0;
      r0 = result_reg;
      cmd(START_NOW);
      for (int i = 0; i < (1 << k); i++)
      begin
         if (i > 0 && (m == MODE_SERIES || m == MODE_SERIES_SCL))
            cmd(START_NOW);
         wait_start(n);
         if (i > 0)
            chkv(n, 0, "back to back");
         step();
         c = corner ? (d ? 12'h800 : 12'hFFF) : seed[11:0];
         sum += d ? int'($signed(c)) : int'(c);
         conv(c);
         chkv({16'h0000, sample_reg}, {16'h0000, exp_smp(m, d, la, c)}, "acc sample");
         if (m == MODE_SERIES || m == MODE_SERIES_SCL)
            chkb(busy, 1'b0, "series one per trigger");
         if (i < (1 << k) - 1)
            chkv(result_reg, r0, "early result");
      end
      sh = int'(k) - 4;
      sc = (sh >= 0) ? (sum >>> sh) : (sum <<< -sh);
      if (m == MODE_SERIES || m == MODE_BURST)
         chkv(result_reg, d ? {{8{sum[23]}}, sum[23:0]} : {8'h00, sum[23:0]}, "sum");
      else
         chkv(result_reg, d ? {{16{sc[15]}}, sc[15:0]} : {16'h0, sc[15:0]}, "scaled");
      chkb(irq_flag_reg[FLG_RES], 1'b1, "result ready");
      chkb(busy, 1'b0, "burst ends");
   endtask

   initial
   begin
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      @(negedge clk);
      chkv({busy, conv_start, irq, irq_flag_reg, sample_reg}, 22'h0, "reset outputs");
      chkv(result_reg, 32'h0, "reset result");
      pulse(0, 6'h01);
      chkb(busy, 1'b0, "event ignored in stop mode");
      for (int i = 0; i < 24; i++)
         one(i[0] ? MODE_SINGLE12 : MODE_SINGLE8, i[1], i[2]);
      acc(MODE_SERIES, 4'h2, 1'b0, 1'b1, 1'b0);
      acc(MODE_SERIES_SCL, 4'h3, 1'b1, 1'b1, 1'b0);
      acc(MODE_BURST, 4'hA, 1'b0, 1'b0, 1'b1);
      acc(MODE_BURST, 4'hA, 1'b1, 1'b1, 1'b1);
      acc(MODE_BURST_SCL, 4'h1, 1'b1, 1'b0, 1'b0);
      acc(MODE_BURST_SCL, 4'h6, 1'b0, 1'b1, 1'b0);
      @(posedge clk) continuous_run <= 1'b1;
      acc(MODE_SERIES, 4'h1, 1'b1, 1'b0, 1'b0);
      // free-running single conversions, then stop
      cfg(MODE_SINGLE12, 1'b0, 1'b0, 4'h0);
      cmd(START_NOW);
      for (int i = 0; i < 3; i++)
      begin
         wait_start(n);
         chkv(n, 0, "free run restart");
         conv(12'h5A5);
      end
      cmd(START_STOP);
      chkb(busy, 1'b0, "stop free run");
      @(posedge clk) continuous_run <= 1'b0;
      // overrun while busy
      cfg(MODE_SINGLE12, 1'b0, 1'b0, 4'h0);
      cmd(START_NOW);
      wait_start(n);
      cmd(START_NOW);
      @(negedge clk);
      chkb(irq_flag_reg[FLG_OVR], 1'b1, "overrun");
      chkb(irq, |(irq_control_reg & 3'h4), "overrun irq");
      chkb(conv_start, 1'b0, "overrun ignored");
      conv(12'h123);
      chkv({16'h0000, sample_reg}, 32'h123, "after overrun");
      // stop aborts and a new start follows at once
      cmd(START_NOW);
      wait_start(n);
      cmd(START_STOP);
      chkb(busy, 1'b0, "abort");
      cmd(START_NOW);
      wait_start(n);
      chkv(n, 0, "restart");
      conv(12'h0FF);
      // event and selector triggers
      cmd(START_EVENT);
      for (int w = 0; w < 3; w++)
      begin
         if (w == 1)
            cmd(START_MUXWR);
         pulse(w, 6'h02);
         wait_start(n);
         chkv(n, 0, "trigger source");
         conv(12'hABC);
         chkv({16'h0000, sample_reg}, 32'hABC, "trigger sample");
      end
      // internal select aborts, next start waits out settle time
      cmd(START_NOW);
      wait_start(n);
      pulse(1, SEL_TEMP);
      chkb(busy, 1'b0, "select abort");
      cmd(START_NOW);
      wait_start(n);
      chkb(n >= SETTLE_CYC && n <= SETTLE_CYC + 2, 1'b1, "settle after select");
      conv(12'h321);
      cmd(START_NOW);
      wait_start(n);
      pulse(3, 6'h00);
      chkb(busy, 1'b0, "reference abort");
      cmd(START_NOW);
      wait_start(n);
      chkb(n >= SETTLE_CYC && n <= SETTLE_CYC + 2, 1'b1, "settle after reference");
      conv(12'h777);
      chkv({16'h0000, sample_reg}, 32'h777, "after settle");
      stop_test();
   end
endmodule // tb

// >>> core/acs_clkdiv.sv
// Purpose: converter clock divider
// Assumes: ratio is two to the power of (select plus one)
// Notes: select changes take effect within the current half period
`timescale 1ns/1ps
module acs_clkdiv
   import acs_pkg::*;
#(
   parameter int SEL_W = 3
)
(
   input wire logic clk,
   input wire logic rst,
   input wire logic [SEL_W-1:0] clock_divider_sel,
   output logic adc_clk
);
   localparam int HALF_W = 1 << SEL_W;

   initial
   begin
      if (SEL_W < 1 || SEL_W > 4)
         $error("acs_clkdiv: SEL_W out of range");
   end

   logic [HALF_W-1:0] cnt_reg;
   logic [HALF_W-1:0] cnt_next;
   logic clk_reg;
   wire [HALF_W-1:0] half_lim = (HALF_W'(1) << clock_divider_sel) - HALF_W'(1);
   wire toggle = (cnt_reg >= half_lim);

   // -----------------------------------------------------------------
   // half period counter
   // -----------------------------------------------------------------
   assign cnt_next = toggle ? '0 : cnt_reg + HALF_W'(1);
   assign adc_clk = clk_reg;

   // counter and clock flip-flop
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         cnt_reg <= '0;
         clk_reg <= 1'b0;
      end
      else
      begin
         cnt_reg <= cnt_next;
         clk_reg <= clk_reg ^ toggle;
      end
   end

   AST_DIV_HALF: assert property (@(posedge clk) disable iff (rst)
      $changed(clk_reg) |-> $past(cnt_reg) >= $past(half_lim))
      else $error("converter clock toggled early");
endmodule // acs_clkdiv

// >>> core/acs_pkg.sv
// Purpose: shared constants and types of the conversion sequencer
// Assumes: 50 MHz peripheral clock
// Notes: internal input codes and settle time are plain defaults
package acs_pkg;
   // ----------------------------------------------------------------
   // operation modes and start field
   // ----------------------------------------------------------------
   localparam logic [2:0] MODE_SINGLE8 = 3'h0;
   localparam logic [2:0] MODE_SINGLE12 = 3'h1;
   localparam logic [2:0] MODE_SERIES = 3'h2;
   localparam logic [2:0] MODE_SERIES_SCL = 3'h3;
   localparam logic [2:0] MODE_BURST = 3'h4;
   localparam logic [2:0] MODE_BURST_SCL = 3'h5;
   localparam logic [1:0] START_STOP = 2'h0;
   localparam logic [1:0] START_NOW = 2'h1;
   localparam logic [1:0] START_EVENT = 2'h2;
   localparam logic [1:0] START_MUXWR = 2'h3;
   // ----------------------------------------------------------------
   // internal input selector codes that abort a conversion
   // ----------------------------------------------------------------
   localparam logic [5:0] SEL_DIVREF = 6'h30;
   localparam logic [5:0] SEL_TEMP = 6'h31;
   localparam logic [5:0] SEL_SUPPLY = 6'h32;
   // ----------------------------------------------------------------
   // flag positions, widths, shifts
   // ----------------------------------------------------------------
   localparam int FLG_RES = 0;
   localparam int FLG_SMP = 1;
   localparam int FLG_OVR = 2;
   localparam int CONV_W = 12;
   localparam int BYTE_W = 8;
   localparam int SAMPLE_W = 16;
   localparam int RESULT_W = 32;
   localparam int ACC_W = 24;
   localparam int CNT_W = 11;
   localparam int MAX_ACC_SEL = 10;
   localparam logic [3:0] ADJ_SHIFT = 4'h4;
   // ----------------------------------------------------------------
   // timing
   // ----------------------------------------------------------------
   localparam int CLK_NS = 20;
   localparam int SETTLE_NS = 1000;
   localparam int SETTLE_CYC = (SETTLE_NS + CLK_NS - 1) / CLK_NS;
   localparam int SETTLE_W = 8;
   // ----------------------------------------------------------------
   // sequencer states, one-hot
   // ----------------------------------------------------------------
   typedef enum logic [3:0] {
      ACS_IDLE = 4'h1,
      ACS_SETTLE = 4'h2,
      ACS_START = 4'h4,
      ACS_WAIT = 4'h8
   } acs_state_t;
endpackage

// >>> core/acs_sequencer.sv
// Purpose: conversion sequencer, accumulator and output formatting
// Assumes: converter core returns clamped codes, 8-bit codes in [7:0]
// Notes: flags are sticky; a set beats a clear in the same cycle
//
// Behaviour
// - six modes 0..5 from mode field, each single-ended or differential.
// - single modes convert once per trigger, result updated every conversion.
// - series modes convert once per trigger, result after the full count.
// - burst modes run the full count back to back from one trigger.
// - series and burst use 12-bit conversions; count from accum_count_sel.
// - accumulator is cleared whenever a new accumulation begins.
// - start by start_now_cmd command, event input, or input selector write.
// - continuous_run repeats single and burst work, not series.
// - stop value aborts conversion; a new one may start at once.
// - trigger while busy is ignored and sets the overrun flag.
// - sample and result ready flags raise interrupt when enabled.
// - reference write or internal input select during conversion aborts.
// - after such abort the next conversion waits out settle time first.
// - sample register always takes the latest conversion.
// - accumulation end loads result; single modes copy the sample.
// - accumulator wide enough for every supported count.
// - scaled modes shift the sum right by count select minus four.
// - left_align shifts sample in supporting modes, result only in 12-bit single mode.
// - single-ended outputs are unsigned and zero extended.
// - differential outputs are two's complement, sign extended.
// - unused upper bits read zero; unscaled accumulations fill bits 23 to 0.
// - differential_sel selects difference conversion; latched with the mode at the trigger that begins an accumulation.
// - left_align ignored in 8-bit and unscaled accumulation modes.
// - converter clock is peripheral clock divided by two to the power of (select plus one).
`timescale 1ns/1ps
module acs_sequencer
   import acs_pkg::*;
#(
   parameter int ACC_SEL_MAX = MAX_ACC_SEL,
   parameter int DIV_SEL_W = 3
)
(
   input wire logic clk,
   input wire logic rst,
   input wire logic [2:0] mode_sel,
   input wire logic differential_sel,
   input wire logic [1:0] start_sel,
   input wire logic command_wr,
   input wire logic event_in,
   input wire logic [5:0] positive_input_sel,
   input wire logic pos_sel_wr,
   input wire logic [5:0] negative_input_sel,
   input wire logic neg_sel_wr,
   input wire logic reference_sel_wr,
   input wire logic [3:0] accum_count_sel,
   input wire logic continuous_run,
   input wire logic left_align,
   input wire logic [DIV_SEL_W-1:0] clock_divider_sel,
   input wire logic [2:0] irq_control_reg,
   input wire logic [2:0] flag_clear,
   input wire logic conv_done,
   input wire logic [CONV_W-1:0] conv_data,
   output logic conv_start,
   output logic conv_res8,
   output logic conv_differential_sel,
   output logic adc_clk,
   output logic busy,
   output logic [2:0] irq_flag_reg,
   output logic irq,
   output logic [SAMPLE_W-1:0] sample_reg,
   output logic [RESULT_W-1:0] result_reg
);
   initial
   begin
      if (ACC_SEL_MAX < 1 || ACC_SEL_MAX > MAX_ACC_SEL)
         $error("acs_sequencer: ACC_SEL_MAX out of range");
   end

   // -----------------------------------------------------------------
   // decoding helpers
   // -----------------------------------------------------------------
   function automatic logic is_internal(input logic [5:0] sel);
      is_internal = (sel == SEL_DIVREF) || (sel == SEL_TEMP) || (sel == SEL_SUPPLY);
   endfunction

   function automatic logic mode_accum(input logic [2:0] m);
      mode_accum = (m != MODE_SINGLE8) && (m != MODE_SINGLE12);
   endfunction

   acs_state_t state_reg, state_next;
   logic [2:0] mode_reg;
   logic differential_sel_reg;
   logic [3:0] ksel_reg;
   logic [CNT_W-1:0] cnt_reg;
   logic [ACC_W-1:0] acc_reg;
   logic settle_pend_reg;
   logic [SETTLE_W-1:0] settle_reg;
   logic [2:0] flag_set;

   // -----------------------------------------------------------------
   // trigger and abort decode
   // -----------------------------------------------------------------
   wire mux_wr = pos_sel_wr | neg_sel_wr;
   wire int_sel = (pos_sel_wr & is_internal(positive_input_sel)) |
                  (neg_sel_wr & is_internal(negative_input_sel));
   wire stop_cmd = command_wr & (start_sel == START_STOP);
   wire settle_abort = int_sel | (reference_sel_wr & busy);
   wire abort = stop_cmd | settle_abort;
   logic [1:0] start_mode_reg;
   wire trig = (command_wr & (start_sel == START_NOW)) |
               (event_in & (start_mode_reg == START_EVENT)) |
               (mux_wr & (start_mode_reg == START_MUXWR));
   wire idle = (state_reg == ACS_IDLE);
   wire take = trig & idle & ~abort;
   wire overrun = trig & ~idle & ~abort;
   wire new_accum = take & (cnt_reg == '0);

   // -----------------------------------------------------------------
   // sample formatting
   // -----------------------------------------------------------------
   wire is8 = (mode_reg == MODE_SINGLE8);
   wire sgn = differential_sel_reg & (is8 ? conv_data[BYTE_W-1] : conv_data[CONV_W-1]);
   wire adj_ok = left_align & ((mode_reg == MODE_SINGLE12) |
                 (mode_reg == MODE_SERIES_SCL) | (mode_reg == MODE_BURST_SCL));
   wire [SAMPLE_W-1:0] samp_raw = is8 ?
      {{(SAMPLE_W-BYTE_W){sgn}}, conv_data[BYTE_W-1:0]} :
      {{(SAMPLE_W-CONV_W){sgn}}, conv_data};
   wire [SAMPLE_W-1:0] samp_fmt = adj_ok ?
      {conv_data, {(SAMPLE_W-CONV_W){1'b0}}} : samp_raw;

   // -----------------------------------------------------------------
   // accumulation and scaling
   // -----------------------------------------------------------------
   wire [ACC_W-1:0] conv_ext = {{(ACC_W-CONV_W){sgn}}, conv_data};
   wire [ACC_W-1:0] acc_base = (cnt_reg == '0) ? '0 : acc_reg;
   wire [ACC_W-1:0] acc_sum = acc_base + conv_ext;
   wire signed [ACC_W-1:0] acc_s = acc_sum;
   wire scale_down = (ksel_reg >= ADJ_SHIFT);
   wire [3:0] sh_dn = ksel_reg - ADJ_SHIFT;
   wire [3:0] sh_up = ADJ_SHIFT - ksel_reg;
   wire signed [ACC_W-1:0] acc_scaled = scale_down ? (acc_s >>> sh_dn) : (acc_s << sh_up);
   wire [SAMPLE_W-1:0] scl16 = acc_scaled[SAMPLE_W-1:0];
   wire scaled_mode = (mode_reg == MODE_SERIES_SCL) | (mode_reg == MODE_BURST_SCL);
   wire burst_mode = (mode_reg == MODE_BURST) | (mode_reg == MODE_BURST_SCL);
   wire [CNT_W-1:0] n_samples = CNT_W'(1) << ksel_reg;
   wire [CNT_W-1:0] cnt_inc = cnt_reg + CNT_W'(1);
   wire last = ~mode_accum(mode_reg) | (cnt_inc == n_samples);
   wire done = (state_reg == ACS_WAIT) & conv_done;
   wire repeat_run = continuous_run & ~mode_accum(mode_reg) | continuous_run & burst_mode;

   // -----------------------------------------------------------------
   // result selection
   // -----------------------------------------------------------------
   wire [RESULT_W-1:0] res_single = {{(RESULT_W-SAMPLE_W){differential_sel_reg & samp_fmt[SAMPLE_W-1]}},
                                     samp_fmt};
   wire [RESULT_W-1:0] res_scaled = {{(RESULT_W-SAMPLE_W){differential_sel_reg & scl16[SAMPLE_W-1]}},
                                     scl16};
   wire [RESULT_W-1:0] res_full = {{(RESULT_W-ACC_W){differential_sel_reg & acc_sum[ACC_W-1]}},
                                   acc_sum};
   wire [RESULT_W-1:0] res_next = ~mode_accum(mode_reg) ? res_single :
                                  (scaled_mode ? res_scaled : res_full);

   // -----------------------------------------------------------------
   // state transitions
   // -----------------------------------------------------------------
   always_comb
   begin
      state_next = state_reg;
      unique case (state_reg)
         ACS_IDLE:
            if (take)
               state_next = settle_pend_reg ? ACS_SETTLE : ACS_START;
         ACS_SETTLE:
            if (settle_reg == '0)
               state_next = ACS_START;
         ACS_START:
            state_next = ACS_WAIT;
         ACS_WAIT:
            if (conv_done)
            begin
               if (!last && burst_mode)
                  state_next = ACS_START;
               else if (last && repeat_run)
                  state_next = ACS_START;
               else
                  state_next = ACS_IDLE;
            end
         default:
            state_next = ACS_IDLE;
      endcase
      if (abort)
         state_next = ACS_IDLE;
   end

   assign busy = ~idle;
   assign conv_start = (state_reg == ACS_START);
   assign conv_res8 = is8;
   assign conv_differential_sel = differential_sel_reg;
   assign flag_set = {overrun, done, done & last};
   assign irq = |(irq_flag_reg & irq_control_reg);

   // state, configuration latch, counters
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         state_reg <= ACS_IDLE;
         start_mode_reg <= START_STOP;
         mode_reg <= MODE_SINGLE8;
         differential_sel_reg <= 1'b0;
         ksel_reg <= 4'h0;
         cnt_reg <= '0;
         acc_reg <= '0;
      end
      else
      begin
         state_reg <= state_next;
         if (command_wr)
            start_mode_reg <= start_sel;
         if (new_accum)
         begin
            mode_reg <= mode_sel;
            differential_sel_reg <= differential_sel;
            ksel_reg <= accum_count_sel;
            acc_reg <= '0;
         end
         if (abort)
            cnt_reg <= '0;
         else if (done)
         begin
            cnt_reg <= last ? '0 : cnt_inc;
            acc_reg <= acc_sum;
         end
      end
   end

   // settle tracking after a settle-worthy abort
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         settle_pend_reg <= 1'b0;
         settle_reg <= '0;
      end
      else
      begin
         if (settle_abort | reference_sel_wr)
            settle_pend_reg <= 1'b1;
         else if (state_reg == ACS_SETTLE && settle_reg == '0)
            settle_pend_reg <= 1'b0;
         if (take)
            settle_reg <= SETTLE_W'(SETTLE_CYC - 1);
         else if (settle_reg != '0)
            settle_reg <= settle_reg - SETTLE_W'(1);
      end
   end

   // output registers and sticky flags, set beats clear
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         sample_reg <= '0;
         result_reg <= '0;
         irq_flag_reg <= '0;
      end
      else
      begin
         if (done)
            sample_reg <= samp_fmt;
         if (done && last)
            result_reg <= res_next;
         irq_flag_reg <= (irq_flag_reg & ~flag_clear) | flag_set;
      end
   end

   // -----------------------------------------------------------------
   // converter clock
   // -----------------------------------------------------------------
   acs_clkdiv #(.SEL_W(DIV_SEL_W)) u_clkdiv (
      .clk(clk),
      .rst(rst),
      .clock_divider_sel(clock_divider_sel),
      .adc_clk(adc_clk)
   );

   // -----------------------------------------------------------------
   // checks
   // -----------------------------------------------------------------
   AST_OVERRUN: assert property (@(posedge clk) disable iff (rst)
      trig && busy && !abort && !done |=> irq_flag_reg[FLG_OVR] && $stable(cnt_reg))
      else $error("overrun not flagged");
   AST_SAMPLE: assert property (@(posedge clk) disable iff (rst)
      done |=> sample_reg == $past(samp_fmt) && irq_flag_reg[FLG_SMP])
      else $error("sample not loaded");
   AST_SINGLE_RES: assert property (@(posedge clk) disable iff (rst)
      done && !mode_accum(mode_reg) |=> result_reg[SAMPLE_W-1:0] == sample_reg)
      else $error("single result differs from sample");
   AST_SERIES_HOLD: assert property (@(posedge clk) disable iff (rst)
      done && !last |=> $stable(result_reg) &&
         (!irq_flag_reg[FLG_RES] || $past(irq_flag_reg[FLG_RES])))
      else $error("result changed mid accumulation");
   AST_ABORT: assert property (@(posedge clk) disable iff (rst)
      abort |=> state_reg == ACS_IDLE && cnt_reg == '0)
      else $error("abort did not stop");
   AST_START_NOW: assert property (@(posedge clk) disable iff (rst)
      take && !settle_pend_reg |=> conv_start)
      else $error("start_now_cmd start missed");
   AST_SETTLE: assert property (@(posedge clk) disable iff (rst)
      take && settle_pend_reg |=> !conv_start [*2])
      else $error("settle time skipped");
   AST_SERIES_IDLE: assert property (@(posedge clk) disable iff (rst)
      done && mode_accum(mode_reg) && !burst_mode |=> state_reg == ACS_IDLE)
      else $error("series ran on without trigger");
   AST_BURST: assert property (@(posedge clk) disable iff (rst)
      done && burst_mode && !last && !abort |=> conv_start ##1 !conv_start)
      else $error("burst did not continue");
   AST_UNSIGNED: assert property (@(posedge clk) disable iff (rst)
      done && last && !differential_sel_reg && !adj_ok |=> result_reg[RESULT_W-1:ACC_W] == '0)
      else $error("single-ended upper bits not zero");

   COV_BURST_DONE: cover property (@(posedge clk) disable iff (rst)
      done && last && burst_mode);
   COV_SERIES_DONE: cover property (@(posedge clk) disable iff (rst)
      done && last && mode_accum(mode_reg) && !burst_mode);
   COV_OVERRUN: cover property (@(posedge clk) disable iff (rst) overrun);
   COV_SETTLE: cover property (@(posedge clk) disable iff (rst)
      state_reg == ACS_SETTLE ##1 state_reg == ACS_START);
endmodule // acs_sequencer
